/* File: common/ebi_pkg.sv */
// Package for the external bus interface: register map, reset values, types
package ebi_pkg;

  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_IRQ_MODE = 5'h04;
  localparam logic [4:0] REG_ROM_SEL = 5'h08;
  localparam logic [4:0] REG_CS_ONE = 5'h0C;
  localparam logic [4:0] REG_CS_TWO = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;

  // Control field positions
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_PCLK_EN = 2;
  localparam int CTRL_ROM_FORCE = 3;
  localparam int CTRL_CS1_EN = 4;
  localparam int CTRL_CS2_EN = 5;

  // Reset values
  localparam logic [1:0] RST_DIV = 2'h0;
  localparam logic RST_PCLK_EN = 1'b1;
  localparam logic RST_ROM_FORCE = 1'b1;
  localparam logic [5:0] RST_IRQ_MODE = 6'h00;
  localparam logic [7:0] RST_ROM_BASE = 8'h00;
  localparam logic [7:0] RST_ROM_MASK = 8'h80;
  localparam logic [15:0] RST_CS_BASE = 16'h0000;
  localparam logic [15:0] RST_CS_MASK = 16'hFFFF;

  // Interrupt sense modes
  localparam logic [1:0] IRQ_LOW = 2'h0;
  localparam logic [1:0] IRQ_HIGH = 2'h1;
  localparam logic [1:0] IRQ_FALL = 2'h2;
  localparam logic [1:0] IRQ_RISE = 2'h3;

  typedef enum logic [2:0] {
    KIND_MEM_RD,
    KIND_MEM_WR,
    KIND_FETCH,
    KIND_IO_RD,
    KIND_IO_WR,
    KIND_INTERRUPT_ACK_OUTPUT
  } ebi_kind_e;

  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4} ebi_state_e;

  // Core-side transaction request
  typedef struct packed {
    logic valid;
    ebi_kind_e kind;
    logic word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ebi_req_s;

  // Core-side answer
  typedef struct packed {
    logic done;
    logic [15:0] rdata;
  } ebi_rsp_s;

  // Bus strobes, all active low
  typedef struct packed {
    logic mrd_n;
    logic mwr_n;
    logic periph_request_n;
    logic periph_read_strobe_n;
    logic periph_write_strobe_n;
    logic m1_n;
    logic [1:0] be_n;
    logic boot_rom_select_n;
    logic [1:0] iocs_n;
  } ebi_strobe_s;

endpackage

/* File: hw/ebi_pclk_div.sv */
// Peripheral clock divider: bus clock divided by 2, 4, 6 or 8
`timescale 1ns/100ps
module ebi_pclk_div (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic [1:0] div_sel_i,
  output logic periph_clock_o,
  output logic tick_o
);

  typedef struct packed {
    logic [1:0] cnt;
    logic level;
    logic tick;
  } ebi_div_s;

  ebi_div_s q, d;

  // Half period is div_sel + 1 bus clocks
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!enable_i) begin
      d.cnt = 2'h0;
      d.level = 1'b0;
    end else if (q.cnt >= div_sel_i) begin
      d.cnt = 2'h0;
      d.level = ~q.level;
      d.tick = ~q.level;
    end else begin
      d.cnt = q.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign periph_clock_o = q.level;
  assign tick_o = q.tick;

endmodule

/* File: hw/ebi_top.sv */
// External bus interface: strobes, byte lanes, selects, interrupts, status
// Functional notes
// - Word: even byte low lanes, odd high
// - Two status outputs encode run/halt/sleep/standby
// - Maskable inputs 1-3: low, high, fall, rise
// - Input zero ORed with on-chip requests
// - Peripheral clock divides bus clock 2/4/6/8
// - Peripheral clock off: I/O uses bus clock
// - Peripheral request held through I/O, acknowledge
// - Peripheral read/write strobes pulse on I/O
// - Two peripheral selects: programmable base/range
// - Fetch marker on fetch and acknowledge
// - Memory read strobe: end T1 to T4
// - Memory write strobe: end T2 to T4
// - Narrow word: second low-lane transaction
// - Boot select decoder pulls narrow flag open-drain
// - Unmaskable falling edge, above all maskable
// - After reset: boot select, narrow when A23=0
// - Boot select range software reprogrammable
// - Byte enables asserted at memory transaction start
`timescale 1ns/100ps
module ebi_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire ebi_pkg::ebi_req_s core_req_i,
  output logic core_ready_o,
  output ebi_pkg::ebi_rsp_s core_rsp_o,
  input wire logic core_halt_i,
  input wire logic core_sleep_i,
  input wire logic core_standby_i,
  input wire logic [3:0] ext_irq_n_i,
  input wire logic nmi_n_i,
  input wire logic [2:0] onchip_irq_n_i,
  input wire logic [3:1] irq_ack_i,
  input wire logic nmi_ack_i,
  output logic [3:0] irq_o,
  output logic nmi_o,
  output logic [23:0] address_o,
  input wire logic [15:0] data_bus_lines_i,
  output logic [15:0] data_bus_lines_o,
  output logic data_bus_lines_oe_o,
  input wire logic narrow_memory_flag_i,
  output logic narrow_memory_flag_o,
  output logic narrow_memory_flag_oe_o,
  output ebi_pkg::ebi_strobe_s strobe_o,
  output logic periph_clock_o,
  output logic halt_n_o,
  output logic low_power_status_n_o
);

  typedef struct packed {
    ebi_pkg::ebi_state_e st;
    logic second;
    logic narrow;
    ebi_pkg::ebi_req_s req;
    logic [15:0] rdata;
    logic done;
    ebi_pkg::ebi_strobe_s pins;
    logic [23:0] addr;
    logic [15:0] dout;
    logic d_oe;
    logic msz_oe;
    logic [1:0] div;
    logic pclk_en;
    logic rom_force;
    logic [1:0] cs_en;
    logic [5:0] irq_mode;
    logic [7:0] rom_base;
    logic [7:0] rom_mask;
    logic [1:0][15:0] cs_base;
    logic [1:0][15:0] cs_mask;
    logic ack;
    logic [31:0] rd;
    logic [3:0] irq_s1;
    logic [3:0] irq_s2;
    logic [3:0] irq_prev;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_prev;
    logic [15:0] d_s1;
    logic [15:0] d_s2;
    logic msz_s1;
    logic msz_s2;
    logic [3:1] pend;
    logic nmi_pend;
    logic halt_n;
    logic lp_n;
  } ebi_top_s;

  ebi_top_s q, d;
  logic tick;
  logic [3:1] irq_act;

  ebi_pclk_div u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(q.pclk_en),
    .div_sel_i(q.div),
    .periph_clock_o(periph_clock_o),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Per-input sense selection
  for (genvar i = 1; i < 4; i++) begin : g_irq
    logic [1:0] mode;
    assign mode = q.irq_mode[2*i-2 +: 2];
    assign irq_act[i] = (mode == ebi_pkg::IRQ_LOW) ? ~q.irq_s2[i] :
                        (mode == ebi_pkg::IRQ_HIGH) ? q.irq_s2[i] : q.pend[i];
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic step;
    logic is_io;
    logic is_rd;
    logic rom_hit;
    logic [31:0] img;
    step = 1'b0;
    is_io = 1'b0;
    is_rd = 1'b0;
    rom_hit = 1'b0;
    img = '0;
    d = q;
    d.done = 1'b0;

    // Synchronisers: first stage feeds only the second
    d.irq_s1 = ext_irq_n_i;
    d.irq_s2 = q.irq_s1;
    d.irq_prev = q.irq_s2;
    d.nmi_s1 = nmi_n_i;
    d.nmi_s2 = q.nmi_s1;
    d.nmi_prev = q.nmi_s2;
    d.d_s1 = data_bus_lines_i;
    d.d_s2 = q.d_s1;
    d.msz_s1 = narrow_memory_flag_i;
    d.msz_s2 = q.msz_s1;

    // Edge capture, set wins over acknowledge
    for (int i = 1; i < 4; i++) begin
      if (irq_ack_i[i]) begin
        d.pend[i] = 1'b0;
      end
      if (q.irq_mode[2*i-1] && ((q.irq_mode[2*i-2] && q.irq_s2[i] && !q.irq_prev[i]) ||
          (!q.irq_mode[2*i-2] && !q.irq_s2[i] && q.irq_prev[i]))) begin
        d.pend[i] = 1'b1;
      end
    end
    if (nmi_ack_i) begin
      d.nmi_pend = 1'b0;
    end
    if (!q.nmi_s2 && q.nmi_prev) begin
      d.nmi_pend = 1'b1;
    end

    // Status encoding
    d.lp_n = ~(core_standby_i | core_sleep_i);
    d.halt_n = ~(core_standby_i | (core_halt_i & ~core_sleep_i));

    // Register slave
    // Registers change only at the edge that sees waitrequest low
    d.ack = (avs_read_i || avs_write_i) && !q.ack;
    if (avs_read_i || avs_write_i) begin
      case (avs_address_i)
        ebi_pkg::REG_CTRL: img = {26'h0, q.cs_en, q.rom_force, q.pclk_en, q.div};
        ebi_pkg::REG_IRQ_MODE: img = {26'h0, q.irq_mode};
        ebi_pkg::REG_ROM_SEL: img = {16'h0, q.rom_mask, q.rom_base};
        ebi_pkg::REG_CS_ONE: img = {q.cs_mask[0], q.cs_base[0]};
        ebi_pkg::REG_CS_TWO: img = {q.cs_mask[1], q.cs_base[1]};
        ebi_pkg::REG_STATUS: img = {26'h0, q.narrow, q.pend, q.nmi_pend, q.st != ebi_pkg::ST_IDLE};
        default: img = '0;
      endcase
      if (!q.ack) begin
        d.rd = img;
      end
      if (avs_write_i && q.ack) begin
        img = merge(img, avs_writedata_i, avs_byteenable_i);
        case (avs_address_i)
          ebi_pkg::REG_CTRL: begin
            d.div = img[ebi_pkg::CTRL_DIV_LSB +: 2];
            d.pclk_en = img[ebi_pkg::CTRL_PCLK_EN];
            d.rom_force = img[ebi_pkg::CTRL_ROM_FORCE];
            d.cs_en = img[ebi_pkg::CTRL_CS2_EN -: 2];
          end
          ebi_pkg::REG_IRQ_MODE: d.irq_mode = img[5:0];
          ebi_pkg::REG_ROM_SEL: {d.rom_mask, d.rom_base} = img[15:0];
          ebi_pkg::REG_CS_ONE: {d.cs_mask[0], d.cs_base[0]} = img;
          ebi_pkg::REG_CS_TWO: {d.cs_mask[1], d.cs_base[1]} = img;
          default: d.ack = 1'b0;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus sequencer
    is_io = q.req.kind inside {ebi_pkg::KIND_IO_RD, ebi_pkg::KIND_IO_WR, ebi_pkg::KIND_INTERRUPT_ACK_OUTPUT};
    is_rd = q.req.kind != ebi_pkg::KIND_MEM_WR && q.req.kind != ebi_pkg::KIND_IO_WR;
    step = !is_io || !q.pclk_en || tick;
    case (q.st)
      ebi_pkg::ST_IDLE: begin
        if (core_req_i.valid) begin
          d.req = core_req_i;
          d.second = 1'b0;
          d.narrow = 1'b0;
          d.st = ebi_pkg::ST_T1;
        end
      end
      ebi_pkg::ST_T1: d.st = step ? ebi_pkg::ST_T2 : q.st;
      ebi_pkg::ST_T2: d.st = step ? ebi_pkg::ST_T3 : q.st;
      ebi_pkg::ST_T3: d.st = step ? ebi_pkg::ST_T4 : q.st;
      ebi_pkg::ST_T4: begin
        if (step) begin
          d.st = ebi_pkg::ST_IDLE;
          // Synchronised lanes lag the pins by two clocks
          if (q.req.word && !q.second && !is_io &&
              (q.msz_oe || !q.msz_s2)) begin
            d.second = 1'b1;
            d.narrow = 1'b1;
            d.st = ebi_pkg::ST_T1;
            if (is_rd) begin
              d.rdata[7:0] = q.d_s2[7:0];
            end
          end else begin
            d.done = 1'b1;
            if (q.second) begin
              d.rdata[15:8] = q.d_s2[7:0];
            end else if (q.req.word || !q.req.addr[0]) begin
              d.rdata = q.d_s2;
            end else begin
              d.rdata = {8'h00, q.d_s2[15:8]};
            end
          end
        end
      end
      default: d.st = ebi_pkg::ST_IDLE;
    endcase

    // Pin values follow the next state
    d.pins = '1;
    d.d_oe = 1'b0;
    d.msz_oe = 1'b0;
    rom_hit = (d.req.addr[23:16] & q.rom_mask) == q.rom_base;
    d.addr = {d.req.addr[23:1], d.req.addr[0] | d.second};
    if (d.st != ebi_pkg::ST_IDLE) begin
      if (d.req.kind inside {ebi_pkg::KIND_IO_RD, ebi_pkg::KIND_IO_WR,
          ebi_pkg::KIND_INTERRUPT_ACK_OUTPUT}) begin
        d.pins.periph_request_n = 1'b0;
        d.pins.m1_n = d.req.kind != ebi_pkg::KIND_INTERRUPT_ACK_OUTPUT;
        for (int c = 0; c < 2; c++) begin
          d.pins.iocs_n[c] = !(q.cs_en[c] && d.req.kind != ebi_pkg::KIND_INTERRUPT_ACK_OUTPUT &&
              ((d.req.addr[15:0] & q.cs_mask[c]) == (q.cs_base[c] & q.cs_mask[c])));
        end
        if (d.st != ebi_pkg::ST_T1) begin
          d.pins.periph_read_strobe_n = d.req.kind != ebi_pkg::KIND_IO_RD;
          d.pins.periph_write_strobe_n = d.req.kind != ebi_pkg::KIND_IO_WR;
        end
        d.d_oe = d.req.kind == ebi_pkg::KIND_IO_WR;
        d.dout = {d.req.wdata[7:0], d.req.wdata[7:0]};
      end else begin
        d.pins.m1_n = d.req.kind != ebi_pkg::KIND_FETCH;
        d.pins.boot_rom_select_n = !rom_hit;
        d.msz_oe = rom_hit && q.rom_force;
        if (d.second) begin
          d.pins.be_n = 2'b10;
        end else if (d.req.word) begin
          d.pins.be_n = 2'b00;
        end else begin
          d.pins.be_n = d.req.addr[0] ? 2'b01 : 2'b10;
        end
        if (d.st != ebi_pkg::ST_T1 && d.req.kind != ebi_pkg::KIND_MEM_WR) begin
          d.pins.mrd_n = 1'b0;
        end
        if ((d.st == ebi_pkg::ST_T3 || d.st == ebi_pkg::ST_T4) &&
            d.req.kind == ebi_pkg::KIND_MEM_WR) begin
          d.pins.mwr_n = 1'b0;
        end
        d.d_oe = d.req.kind == ebi_pkg::KIND_MEM_WR;
        if (d.second) begin
          d.dout = {8'h00, d.req.wdata[15:8]};
        end else if (!d.req.word && d.req.addr[0]) begin
          d.dout = {d.req.wdata[7:0], 8'h00};
        end else begin
          d.dout = d.req.wdata;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= ebi_pkg::ST_IDLE;
      q.pins <= '1;
      q.div <= ebi_pkg::RST_DIV;
      q.pclk_en <= ebi_pkg::RST_PCLK_EN;
      q.rom_force <= ebi_pkg::RST_ROM_FORCE;
      q.irq_mode <= ebi_pkg::RST_IRQ_MODE;
      q.rom_base <= ebi_pkg::RST_ROM_BASE;
      q.rom_mask <= ebi_pkg::RST_ROM_MASK;
      q.cs_base <= {ebi_pkg::RST_CS_BASE, ebi_pkg::RST_CS_BASE};
      q.cs_mask <= {ebi_pkg::RST_CS_MASK, ebi_pkg::RST_CS_MASK};
      q.irq_s1 <= '1;
      q.irq_s2 <= '1;
      q.irq_prev <= '1;
      q.nmi_s1 <= 1'b1;
      q.nmi_s2 <= 1'b1;
      q.nmi_prev <= 1'b1;
      q.msz_s1 <= 1'b1;
      q.msz_s2 <= 1'b1;
      q.halt_n <= 1'b1;
      q.lp_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign avs_readdata_o = q.rd;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !q.ack;
  assign core_ready_o = q.st == ebi_pkg::ST_IDLE;
  assign core_rsp_o = '{done: q.done, rdata: q.rdata};
  // Unmaskable request masks every maskable line while it is pending
  assign irq_o[0] = !q.nmi_pend && (!q.irq_s2[0] || !(&onchip_irq_n_i));
  assign irq_o[3:1] = q.nmi_pend ? 3'h0 : irq_act;
  assign nmi_o = q.nmi_pend;
  assign address_o = q.addr;
  assign data_bus_lines_o = q.dout;
  assign data_bus_lines_oe_o = q.d_oe;
  assign narrow_memory_flag_o = 1'b0;
  assign narrow_memory_flag_oe_o = q.msz_oe;
  assign strobe_o = q.pins;
  assign halt_n_o = q.halt_n;
  assign low_power_status_n_o = q.lp_n;

endmodule

/* File: dv/ebi_top_properties.sv */
// Checker of strobe timing, lane enables, interrupt masking and status
`timescale 1ns/100ps
module ebi_top_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire ebi_pkg::ebi_strobe_s strobe_o,
  input wire logic data_bus_lines_oe_o,
  input wire logic core_halt_i,
  input wire logic core_sleep_i,
  input wire logic core_standby_i,
  input wire logic halt_n_o,
  input wire logic low_power_status_n_o,
  input wire logic nmi_o,
  input wire logic [3:0] irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  sequence rd_hold_s;
    (!strobe_o.mrd_n) [*3] ##1 strobe_o.mrd_n;
  endsequence
  sequence wr_hold_s;
    (!strobe_o.mwr_n) [*2] ##1 strobe_o.mwr_n;
  endsequence
  mem_rd_width_a: assert property ($fell(strobe_o.mrd_n) |-> rd_hold_s)
    else $error("read strobe width wrong");
  mem_wr_width_a: assert property ($fell(strobe_o.mwr_n) |->
    $past(data_bus_lines_oe_o) ##0 wr_hold_s) else $error("write strobe wrong");
  lane_enable_a: assert property ($fell(strobe_o.mrd_n) |->
    $past(strobe_o.be_n) != 2'h3) else $error("no lane enable before read");
  read_no_drive_a: assert property (!strobe_o.mrd_n |-> !data_bus_lines_oe_o)
    else $error("bus driven in read");
  io_read_req_a: assert property (!strobe_o.periph_read_strobe_n |-> !strobe_o.periph_request_n)
    else $error("read strobe without request");
  io_write_req_a: assert property (!strobe_o.periph_write_strobe_n |-> !strobe_o.periph_request_n)
    else $error("write strobe without request");
  fetch_no_write_a: assert property (!strobe_o.m1_n |-> strobe_o.mwr_n)
    else $error("marker on write");
  nmi_masks_all_a: assert property (nmi_o |-> irq_o == 4'h0)
    else $error("maskable request under nmi");
  standby_code_a: assert property (core_standby_i |=>
    !halt_n_o && !low_power_status_n_o) else $error("standby code wrong");
endmodule
bind ebi_top ebi_top_checker chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .strobe_o(strobe_o),
  .data_bus_lines_oe_o(data_bus_lines_oe_o), .core_halt_i(core_halt_i),
  .core_sleep_i(core_sleep_i), .core_standby_i(core_standby_i), .halt_n_o(halt_n_o),
  .low_power_status_n_o(low_power_status_n_o), .nmi_o(nmi_o), .irq_o(irq_o)
);

/* File: dv/ebi_mem_model.sv */
// Memory and peripheral model on the far side of the bus
`timescale 1ns/100ps
module ebi_mem_model (
  input wire logic clk_i,
  input wire logic narrow_i,
  input wire logic pull_i,
  input wire logic [23:0] addr_i,
  input wire ebi_pkg::ebi_strobe_s strobe_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic narrow_n_o
);
  logic [7:0] mem [256];
  logic [15:0] last_q = 16'h0000;
  logic [7:0] a;
  logic [7:0] e;
  assign a = addr_i[7:0];
  assign e = {addr_i[7:1], 1'b0};
  // Pulled-up flag: low while either side pulls it
  assign narrow_n_o = !((narrow_i && strobe_i.be_n != 2'h3) || pull_i);
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i);
  end
  ////////////////////////////////////////
  always @(posedge clk_i) begin
    if (!strobe_i.mwr_n && !narrow_n_o) mem[a] <= wdata_i[7:0];
    else if (!strobe_i.mwr_n) begin
      if (!strobe_i.be_n[0]) mem[e] <= wdata_i[7:0];
      if (!strobe_i.be_n[1]) mem[e + 8'h01] <= wdata_i[15:8];
    end
    if (!strobe_i.mrd_n || !strobe_i.periph_read_strobe_n) last_q <= rdata_o;
  end
  // Released lanes invert, so a stale value never passes
  always_comb begin
    if (!strobe_i.mrd_n && !narrow_n_o) rdata_o = {~mem[a], mem[a]};
    else if (!strobe_i.mrd_n) rdata_o = {mem[e + 8'h01], mem[e]};
    else if (!strobe_i.periph_read_strobe_n) rdata_o = {mem[a], ~mem[a]};
    else rdata_o = ~last_q;
  end
endmodule

/* File: dv/tb_ebi_top.sv */
// Self-checking testbench of the external bus interface
`timescale 1ns/100ps
module tb_ebi_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o, q;
  logic avs_waitrequest_o, core_ready_o, nmi_o, periph_clock_o, halt_n_o, lp_n;
  ebi_pkg::ebi_req_s core_req_i = '0;
  ebi_pkg::ebi_rsp_s core_rsp_o;
  ebi_pkg::ebi_strobe_s strobe_o;
  logic [2:0] st = 3'h0;
  logic [3:0] ext_irq_n_i = 4'hF;
  logic nmi_n_i = 1'b1;
  logic [2:0] onchip_irq_n_i = 3'h7;
  logic [3:1] irq_ack_i = 3'h0;
  logic nmi_ack_i = 1'b0;
  logic narrow = 1'b0;
  logic [3:0] irq_o;
  logic [23:0] address_o;
  logic [15:0] bus_in, bus_out, rdat;
  logic bus_oe, nar_in, nar_out, nar_oe;
  logic [4:0] saw;
  int n_fail = 0;
  int checks_done = 0;
  int n_xfer, n_periph_request;
  ebi_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .core_req_i(core_req_i),
    .core_ready_o(core_ready_o), .core_rsp_o(core_rsp_o), .core_halt_i(st[0]),
    .core_sleep_i(st[1]), .core_standby_i(st[2]), .ext_irq_n_i(ext_irq_n_i),
    .nmi_n_i(nmi_n_i), .onchip_irq_n_i(onchip_irq_n_i), .irq_ack_i(irq_ack_i),
    .nmi_ack_i(nmi_ack_i), .irq_o(irq_o), .nmi_o(nmi_o), .address_o(address_o),
    .data_bus_lines_i(bus_in), .data_bus_lines_o(bus_out), .data_bus_lines_oe_o(bus_oe),
    .narrow_memory_flag_i(nar_in), .narrow_memory_flag_o(nar_out),
    .narrow_memory_flag_oe_o(nar_oe), .strobe_o(strobe_o), .periph_clock_o(periph_clock_o),
    .halt_n_o(halt_n_o), .low_power_status_n_o(lp_n));
  ebi_mem_model mdl_u (.clk_i(clk_i), .narrow_i(narrow), .pull_i(nar_oe),
    .addr_i(address_o), .strobe_i(strobe_o), .wdata_i(bus_out), .rdata_o(bus_in),
    .narrow_n_o(nar_in));
  initial forever #5 clk_i = ~clk_i;
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string w);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", w, exp, seen);
    end
  endtask
  task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Kinds: 0 mem read, 1 mem write, 2 fetch, 3 io read, 4 io write, 5 interrupt_ack_output
  task automatic xact(input logic [2:0] k, input logic [23:0] a, input logic [15:0] d);
    logic p;
    p = 1'b1;
    n_xfer = 0;
    n_periph_request = 0;
    saw = 5'h00;
    core_req_i <= '{1'b1, ebi_pkg::ebi_kind_e'(k), 1'b1, a, d};
    @(posedge clk_i iff core_ready_o === 1'b1);
    core_req_i.valid <= 1'b0;
    do begin
      @(posedge clk_i);
      n_xfer += int'(p && !(strobe_o.mrd_n && strobe_o.mwr_n));
      p = strobe_o.mrd_n && strobe_o.mwr_n;
      n_periph_request += int'(!strobe_o.periph_request_n);
      saw |= {!strobe_o.periph_read_strobe_n, !(strobe_o.m1_n || strobe_o.periph_request_n), !strobe_o.m1_n,
        !strobe_o.iocs_n[0], !strobe_o.boot_rom_select_n};
    end while (core_rsp_o.done !== 1'b1);
    rdat = core_rsp_o.rdata;
  endtask
  ////////////////////////////////////////
  task automatic t_boot;
    avs(1'b0, ebi_pkg::REG_CTRL, 32'h0);
    check(q, {28'h0, ebi_pkg::RST_ROM_FORCE, ebi_pkg::RST_PCLK_EN, ebi_pkg::RST_DIV}, "ctrl");
    avs(1'b0, 5'h18, 32'h0);
    check(q, 32'h0, "unmapped");
    xact(3'h0, 24'h000030, 16'h0000);
    check(n_xfer, 2, "boot passes");
    check(saw[0], 1'b1, "boot select");
    check(rdat, 16'h3130, "boot data");
  endtask
  task automatic t_mem(input logic nw, input logic [7:0] a, input logic [15:0] d);
    narrow <= nw;
    xact(3'h1, {16'h8000, a}, d);
    check(n_xfer, nw ? 2 : 1, "write passes");
    check({mdl_u.mem[a + 8'h01], mdl_u.mem[a]}, d, "stored");
    xact(3'h0, {16'h8000, a}, 16'h0000);
    check(rdat, d, "read back");
    narrow <= 1'b0;
  endtask
  task automatic t_rom;
    avs(1'b1, ebi_pkg::REG_ROM_SEL, 32'h0000FF01);
    xact(3'h0, 24'h010000, 16'h0000);
    check(saw[0], 1'b1, "moved select");
    xact(3'h0, 24'h000030, 16'h0000);
    check(saw[0], 1'b0, "old range");
    check(n_xfer, 1, "no forcing");
    xact(3'h2, 24'h800000, 16'h0000);
    check(saw[2], 1'b1, "fetch marker");
  endtask
  task automatic t_io;
    avs(1'b1, ebi_pkg::REG_CS_ONE, 32'hFFF00040);
    avs(1'b1, ebi_pkg::REG_CTRL, 32'h10);
    xact(3'h3, 24'h000045, 16'h0000);
    check(n_periph_request, 4, "request span");
    check(saw[4:3], 2'h2, "read strobe");
    check(saw[1], 1'b1, "select hit");
    xact(3'h4, 24'h000085, 16'h1234);
    check(saw[1], 1'b0, "select miss");
    xact(3'h5, 24'h000000, 16'h0000);
    check(saw[3], 1'b1, "ack marker");
    avs(1'b1, ebi_pkg::REG_CTRL, 32'h14);
    xact(3'h3, 24'h000045, 16'h0000);
    check(n_periph_request > 6, 1'b1, "slow request");
  endtask
  task automatic t_pclk;
    int n;
    for (int s = 0; s < 4; s++) begin
      avs(1'b1, ebi_pkg::REG_CTRL, 32'h4 | s);
      @(posedge clk_i iff periph_clock_o === 1'b0);
      @(posedge clk_i iff periph_clock_o === 1'b1);
      n = 0;
      do begin @(posedge clk_i); n++; end while (periph_clock_o !== 1'b0);
      do begin @(posedge clk_i); n++; end while (periph_clock_o !== 1'b1);
      check(n, 2 * (s + 1), "divided period");
    end
  endtask
  task automatic t_status;
    logic [1:0] exp [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    for (int i = 0; i < 4; i++) begin
      st <= 3'(1 << i);
      repeat (2) @(posedge clk_i);
      check({lp_n, halt_n_o}, exp[i], "status");
    end
  endtask
  task automatic t_irq;
    for (int m = 0; m < 4; m++) begin
      avs(1'b1, ebi_pkg::REG_IRQ_MODE, 32'(m));
      ext_irq_n_i[1] <= ~m[0];
      repeat (6) @(posedge clk_i);
      irq_ack_i <= 3'h7;
      @(posedge clk_i);
      irq_ack_i <= 3'h0;
      repeat (4) @(posedge clk_i);
      check(irq_o[1], 1'b0, "irq idle");
      ext_irq_n_i[1] <= m[0];
      repeat (6) @(posedge clk_i);
      check(irq_o[1], 1'b1, "irq set");
    end
    nmi_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({nmi_o, irq_o}, 5'h10, "nmi");
    nmi_ack_i <= 1'b1;
    @(posedge clk_i);
    nmi_ack_i <= 1'b0;
    onchip_irq_n_i <= 3'h6;
    repeat (6) @(posedge clk_i);
    check(irq_o[1:0], 2'h3, "after nmi");
  endtask
  task automatic test_done;
    $display("checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_boot();
    avs(1'b1, ebi_pkg::REG_CTRL, 32'h4);
    t_mem(1'b0, 8'h10, 16'hA55A);
    t_mem(1'b1, 8'h20, 16'hBEEF);
    t_rom();
    t_io();
    t_pclk();
    t_status();
    t_irq();
    test_done();
  end
endmodule
